// ---- verif/emx_client_model.sv ----
// Client-side sink that paces and records exception frame bytes
`timescale 1ns/100ps
module emx_client_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Frame bytes from the device
  input  wire logic       txValid,
  input  wire logic [7:0] txByte,
  input  wire logic       txLast,
  output logic            txReady,
  // Pacing from the bench
  input  wire logic       stall
);
  logic [8:0] rxQ[$];

  // ****************************************
  // Byte capture with random stalls
  // ****************************************
  always @(posedge core_clk) begin
    txReady <= !srst && !stall;
    if (!srst && txValid && txReady) begin
      rxQ.push_back({txLast, txByte});
    end
  end
endmodule

// ---- verif/emx_exception_status_monitor.sv ----
// Checker for the exception and status block
`timescale 1ns/100ps
module emx_exception_status_monitor (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // Request side
  input wire logic        reqValid,
  input wire logic        reqCommErr,
  input wire logic        reqBroadcast,
  input wire logic [7:0]  reqFunc,
  input wire logic [7:0]  nodeAddr,
  input wire logic        scaleSet,
  input wire logic        codeSeqSet,
  input wire logic [15:0] alarmVec,
  // Outcome side
  input wire logic        rspValid,
  input wire logic [1:0]  rspKind,
  input wire logic [7:0]  rspFunc,
  input wire logic [7:0]  rspCode,
  input wire logic        senderBusy,
  input wire logic        txValid,
  input wire logic [7:0]  txByte,
  input wire logic        txLast,
  input wire logic        txReady,
  input wire logic [15:0] statusWord
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // ****************************************
  // Steps of a request
  // ****************************************
  sequence reqTaken;
    reqValid && !senderBusy && !$past(reqValid);
  endsequence
  sequence excOut;
    rspValid && rspKind == emx_pkg::RSP_EXCEPT;
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  rsp_one_shot_a: assert property (
    reqTaken |=> rspValid ##1 (!rspValid || $past(reqValid && !senderBusy)))
    else $error("outcome pulse missing");
  fault_quiet_a: assert property (
    reqTaken ##0 (reqCommErr || reqBroadcast) ##1 (!reqValid)[*2] |->
    $past(rspKind == emx_pkg::RSP_NONE && !txValid) ##0
    (rspKind == emx_pkg::RSP_NONE && !txValid)[*2]) else $error("reply to faulty frame");
  func_echo_a: assert property (
    rspValid |-> rspFunc == ($past(reqFunc) | (rspKind == emx_pkg::RSP_EXCEPT ? 8'h80 : 8'h00)))
    else $error("function byte wrong");
  code_present_a: assert property (
    rspValid |-> (rspKind == emx_pkg::RSP_EXCEPT) == (rspCode != 8'h00))
    else $error("exception code mismatch");
  frame_start_a: assert property (
    excOut |-> txValid && txByte == nodeAddr && senderBusy) else $error("frame start wrong");
  byte_hold_a: assert property (
    txValid && !txReady |=> txValid && $stable(txByte) && $stable(txLast))
    else $error("byte dropped on stall");
  frame_end_a: assert property (
    txValid && txLast && txReady |=> !txValid && !senderBusy) else $error("frame tail wrong");
  status_mirror_a: assert property (
    !srst |=>
    statusWord == {7'h00, |$past(alarmVec), 6'h00, $past(codeSeqSet), $past(scaleSet)})
    else $error("status word wrong");
endmodule

bind emx_exception_status emx_exception_status_monitor emx_exception_status_monitor_inst (
  .core_clk, .srst, .reqValid, .reqCommErr, .reqBroadcast, .reqFunc, .nodeAddr, .scaleSet,
  .codeSeqSet, .alarmVec, .rspValid, .rspKind, .rspFunc, .rspCode, .senderBusy, .txValid,
  .txByte, .txLast, .txReady, .statusWord
);

// ---- verif/tb_top.sv ----
// Self-checking bench for the exception and status block
`timescale 1ns/100ps
module tb_top;
  logic        core_clk, srst, reqValid, reqCommErr, reqBroadcast, reqLenOk, devNotReady;
  logic        devFailure, progAccepted, progBusy, memParityErr, gwPathFail, gwTargetFail;
  logic        scaleSet, codeSeqSet, rspValid, senderBusy, txValid, txLast, txReady;
  logic        stall = 1'b0;
  logic [1:0]  rspKind;
  logic [7:0]  reqFunc, nodeAddr, rspFunc, rspCode, txByte;
  logic [7:0]  reqRefType = emx_pkg::FILE_REF_TYPE;
  logic [10:0] cnd;
  logic [15:0] reqStart, reqQty, alarmVec, statusWord;
  logic [31:0] rnd = 32'h0001_6A35;
  logic [23:0] expQ[$];
  logic [23:0] e;
  int          err_total, check_count;

  assign {gwTargetFail, gwPathFail, memParityErr, progAccepted, devFailure} = cnd[10:6];
  assign {progBusy, devNotReady, reqBroadcast, reqCommErr} = cnd[4:1];
  assign reqLenOk = ~cnd[5];

  emx_exception_status #(.HOLD_REGS(11), .INPUT_REGS(7), .FILE_EN(1'b1))
    emx_exception_status_inst (.core_clk, .srst, .reqValid, .reqCommErr, .reqBroadcast,
    .reqFunc, .reqStart, .reqQty, .reqLenOk, .reqRefType, .devNotReady, .devFailure,
    .progAccepted, .progBusy, .memParityErr, .gwPathFail, .gwTargetFail, .nodeAddr,
    .scaleSet, .codeSeqSet, .alarmVec, .rspValid, .rspKind, .rspFunc, .rspCode,
    .senderBusy, .txValid, .txByte, .txLast, .txReady, .statusWord);
  emx_client_model emx_client_model_inst (.core_clk, .srst, .txValid, .txByte, .txLast,
    .txReady, .stall);

  // ****************************************
  // Clock, random source, helpers
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  always @(posedge core_clk) begin
    rnd <= xs(rnd);
    stall <= rnd[0] & rnd[1];
  end
  function automatic logic [15:0] crc3(input logic [23:0] b);
    logic [15:0] c;
    c = emx_pkg::CRC_INIT;
    for (int i = 0; i < 3; i++) begin
      c ^= {8'h00, b[23 - 8 * i -: 8]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ emx_pkg::CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // Outcome scoreboard
  // ****************************************
  always @(negedge core_clk) begin
    if (rspValid === 1'b1) begin
      e = (expQ.size() > 0) ? expQ.pop_front() : 24'hFF_FFFF;
      chk(rspKind == 2'b00 ? 24'h00_0000 : {6'h00, rspKind, rspFunc, rspCode}, e);
    end
  end

  // ****************************************
  // One request with its frame and status
  // ****************************************
  task automatic run(input logic [7:0] f, input logic [15:0] s, q, input int c,
                     input logic [7:0] x);
    logic [7:0] fb[5];
    @(posedge core_clk);
    {reqFunc, reqStart, reqQty} <= {f, s, q};
    cnd <= 11'h001 << c;
    {codeSeqSet, scaleSet, nodeAddr} <= rnd[25:16];
    alarmVec <= rnd[15:0] & {16{rnd[26]}};
    reqValid <= 1'b1;
    expQ.push_back(x != 8'h00 ? {6'h00, 2'b10, f | 8'h80, x} :
                   (c == 1 || c == 2) ? 24'h00_0000 : {6'h00, 2'b01, f, 8'h00});
    @(posedge core_clk);
    reqValid <= 1'b0;
    @(posedge core_clk);
    reqValid <= (x != 8'h00);
    @(posedge core_clk);
    reqValid <= 1'b0;
    for (int i = 0; i < 400 && senderBusy !== 1'b0; i++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    fb = '{nodeAddr, f | 8'h80, x, 8'h00, 8'h00};
    {fb[4], fb[3]} = crc3({fb[0], fb[1], fb[2]});
    chk(24'(emx_client_model_inst.rxQ.size()), (x != 8'h00) ? 24'h00_0005 : 24'h00_0000);
    for (int i = 0; i < 5 && emx_client_model_inst.rxQ.size() > 0; i++)
      chk({15'h0000, emx_client_model_inst.rxQ.pop_front()}, {15'h0000, i == 4, fb[i]});
    chk({8'h00, statusWord}, {8'h00, 7'h00, |alarmVec, 6'h00, codeSeqSet, scaleSet});
    chk(24'(expQ.size()), 24'h00_0000);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    srst = 1'b1;
    {reqValid, cnd, reqFunc, reqStart, reqQty, nodeAddr, alarmVec, scaleSet, codeSeqSet} = '0;
    repeat (20) @(posedge core_clk);
    chk({6'h00, rspKind, rspFunc, rspCode}, 24'h00_0000);
    chk({8'h00, statusWord}, 24'h00_0000);
    srst <= 1'b0;
    run(8'h03, 16'h0000, 16'h000B, 0, 8'h00);
    run(8'h03, 16'h0001, 16'h000B, 0, 8'h02);
    run(8'h04, 16'h0000, 16'h0008, 0, 8'h02);
    run(8'h04, 16'h0006, 16'h0001, 0, 8'h00);
    run(8'h06, 16'h000B, 16'h0000, 0, 8'h02);
    run(8'h10, 16'h0000, 16'h007C, 0, 8'h03);
    run(8'h03, 16'h0000, 16'h0000, 0, 8'h03);
    run(8'h03, 16'h0000, 16'h007E, 0, 8'h03);
    run(8'h03, 16'h0000, 16'h0001, 5, 8'h03);
    run(8'h01, 16'h0000, 16'h0001, 0, 8'h01);
    run(8'h03, 16'h0000, 16'h0001, 3, 8'h01);
    run(8'h10, 16'h0000, 16'h0001, 4, 8'h06);
    run(8'h10, 16'h0000, 16'h0001, 0, 8'h00);
    run(8'h14, 16'h0000, 16'h0000, 8, 8'h08);
    run(8'h15, 16'h0000, 16'h0000, 8, 8'h08);
    reqRefType <= 8'h05;
    run(8'h14, 16'h0000, 16'h0000, 8, 8'h00);
    reqRefType <= emx_pkg::FILE_REF_TYPE;
    run(8'h03, 16'h0000, 16'h0001, 9, 8'h0A);
    run(8'h03, 16'h0000, 16'h0001, 10, 8'h0B);
    run(8'h03, 16'h0000, 16'h0001, 6, 8'h04);
    run(8'h10, 16'h0000, 16'h0001, 7, 8'h05);
    run(8'h03, 16'h0000, 16'h0001, 1, 8'h00);
    run(8'h03, 16'h0000, 16'h0001, 2, 8'h00);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({6'h00, rspKind, rspFunc, rspCode}, 24'h00_0000);
    chk({8'h00, statusWord}, 24'h00_0000);
    srst <= 1'b0;
    run(8'h04, 16'h0009, 16'h0001, 0, 8'h02);
    final_report();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    final_report();
  end
endmodule

// ---- verilog/emx_crc16.sv ----
// Byte-wise frame checksum unit
`timescale 1ns/100ps
module emx_crc16 (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Checksum channel
  emx_crc_if.calc  crcBus
);

  // ****************************************
  // One byte of checksum update
  // ****************************************
  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ emx_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  logic [15:0] crc_q;

  always_ff @(posedge core_clk) begin
    if (srst || crcBus.clear) begin
      crc_q <= emx_pkg::CRC_INIT;
    end else if (crcBus.enable) begin
      crc_q <= crcByte(crc_q, crcBus.data);
    end
  end

  assign crcBus.crc = crc_q;

endmodule

// ---- verilog/emx_crc_if.sv ----
// Carrier between the reply sender and its checksum unit
`timescale 1ns/100ps
interface emx_crc_if;
  logic        clear;
  logic        enable;
  logic [7:0]  data;
  logic [15:0] crc;

  modport calc (
    input  clear,
    input  enable,
    input  data,
    output crc
  );

  modport user (
    output clear,
    output enable,
    output data,
    input  crc
  );
endinterface

// ---- verilog/emx_exception_status.sv ----
// Request outcome, exception reply sender and status word
//
// Function
// - Status bit 1 mirrors counting direction
// - Status bits 2-7, 9-15 unused
// - Status bit 8 set when any alarm
// - Clean serviceable request gets normal reply
// - Faulty or broadcast frame gets no reply
// - Unserviceable clean request gets exception reply
// - Normal reply echoes function code unchanged
// - Exception reply sets function code top bit
// - Exception reply carries an exception code
// - Code 01: function unsupported or wrong state
// - Code 02: address range past last register
// - Code 03: malformed request structure or quantity zero or over limit
// - Code 04: unrecoverable internal failure
// - Code 05: long programming accepted, running
// - Code 06: busy, client resends later
// - Code 08: file record parity fault
// - Code 0A: gateway path unavailable
// - Code 0B: gateway target did not answer
`timescale 1ns/100ps
module emx_exception_status #(
  parameter int HOLD_REGS  = emx_pkg::HOLD_REG_CNT,
  parameter int INPUT_REGS = emx_pkg::INPUT_REG_CNT,
  parameter bit FILE_EN    = 1'b0
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Request from frame receiver
  input  wire logic        reqValid,
  input  wire logic        reqCommErr,
  input  wire logic        reqBroadcast,
  input  wire logic [7:0]  reqFunc,
  input  wire logic [15:0] reqStart,
  input  wire logic [15:0] reqQty,
  input  wire logic        reqLenOk,
  input  wire logic [7:0]  reqRefType,
  // Device conditions
  input  wire logic        devNotReady,
  input  wire logic        devFailure,
  input  wire logic        progAccepted,
  input  wire logic        progBusy,
  input  wire logic        memParityErr,
  input  wire logic        gwPathFail,
  input  wire logic        gwTargetFail,
  input  wire logic [7:0]  nodeAddr,
  // Status sources
  input  wire logic        scaleSet,
  input  wire logic        codeSeqSet,
  input  wire logic [15:0] alarmVec,
  // Outcome
  output logic             rspValid,
  output logic [1:0]       rspKind,
  output logic [7:0]       rspFunc,
  output logic [7:0]       rspCode,
  output logic             senderBusy,
  // Exception frame bytes
  output logic             txValid,
  output logic [7:0]       txByte,
  output logic             txLast,
  input  wire logic        txReady,
  // Status word
  output logic [15:0]      statusWord
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic isImpl(input logic [7:0] f);
    return (f == emx_pkg::FC_READ_HOLD) || (f == emx_pkg::FC_READ_INPUT) ||
           (f == emx_pkg::FC_WRITE_ONE) || (f == emx_pkg::FC_WRITE_MANY) ||
           (FILE_EN && ((f == emx_pkg::FC_FILE_READ) || (f == emx_pkg::FC_FILE_WRITE)));
  endfunction

  function automatic logic isFile(input logic [7:0] f);
    return (f == emx_pkg::FC_FILE_READ) || (f == emx_pkg::FC_FILE_WRITE);
  endfunction

  function automatic logic rangeBad(input logic [15:0] s, input logic [15:0] q,
                                    input int cnt);
    logic [16:0] top;
    top = {1'b0, s} + {1'b0, q};
    return top > 17'(cnt);
  endfunction

  function automatic logic qtyBad(input logic [15:0] q, input logic [15:0] maxq);
    return (q == 16'h0000) || (q > maxq);
  endfunction

  // ****************************************
  // Outcome decision
  // ****************************************
  logic [1:0]  kind;
  logic [7:0]  code;
  logic [15:0] qtyEff;
  logic        isWrite;
  logic        isInput;

  always_comb begin
    isWrite = (reqFunc == emx_pkg::FC_WRITE_ONE) || (reqFunc == emx_pkg::FC_WRITE_MANY);
    isInput = (reqFunc == emx_pkg::FC_READ_INPUT);
    qtyEff  = (reqFunc == emx_pkg::FC_WRITE_ONE) ? 16'h0001 : reqQty;
    kind    = emx_pkg::RSP_EXCEPT;
    code    = 8'h00;
    if (reqCommErr || reqBroadcast) begin
      kind = emx_pkg::RSP_NONE;
    end else if (!isImpl(reqFunc) || devNotReady) begin
      code = emx_pkg::EXC_FUNC;
    end else if (progBusy) begin
      code = emx_pkg::EXC_BUSY;
    end else if (!reqLenOk ||
                 (!isFile(reqFunc) && reqFunc != emx_pkg::FC_WRITE_ONE &&
                  qtyBad(reqQty, isWrite ? emx_pkg::QTY_WRITE_MAX
                                         : emx_pkg::QTY_READ_MAX))) begin
      code = emx_pkg::EXC_VALUE;
    end else if (!isFile(reqFunc) &&
                 rangeBad(reqStart, qtyEff, isInput ? INPUT_REGS : HOLD_REGS)) begin
      code = emx_pkg::EXC_ADDR;
    end else if (isFile(reqFunc) && reqRefType == emx_pkg::FILE_REF_TYPE &&
                 memParityErr) begin
      code = emx_pkg::EXC_PARITY;
    end else if (gwPathFail) begin
      code = emx_pkg::EXC_GW_PATH;
    end else if (gwTargetFail) begin
      code = emx_pkg::EXC_GW_TARGET;
    end else if (devFailure) begin
      code = emx_pkg::EXC_FAILURE;
    end else if (progAccepted) begin
      code = emx_pkg::EXC_ACK;
    end else begin
      kind = emx_pkg::RSP_NORMAL;
    end
  end

  // ****************************************
  // Outcome registers
  // ****************************************
  emx_pkg::emx_tx_t txState_q;
  emx_pkg::emx_tx_t txState_d;
  logic             take;
  logic             acc;

  assign take = reqValid && (txState_q == emx_pkg::TX_IDLE);
  assign acc  = txValid && txReady;

  // Outcome strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rspValid <= 1'b0;
    end else begin
      rspValid <= take;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rspKind <= emx_pkg::RSP_NONE;
    end else if (take) begin
      rspKind <= kind;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rspFunc <= 8'h00;
    end else if (take) begin
      rspFunc <= (kind == emx_pkg::RSP_EXCEPT) ? (reqFunc | emx_pkg::FC_EXC_FLAG)
                                               : reqFunc;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rspCode <= 8'h00;
    end else if (take) begin
      rspCode <= code;
    end
  end

  // ****************************************
  // Checksum unit
  // ****************************************
  emx_crc_if crcBus ();

  emx_crc16 u_crc (
    .core_clk (core_clk),
    .srst     (srst),
    .crcBus   (crcBus)
  );

  assign crcBus.clear  = take;
  assign crcBus.data   = txByte;
  assign crcBus.enable = acc && (txState_q inside {emx_pkg::TX_ADDR, emx_pkg::TX_FUNC,
                                                   emx_pkg::TX_CODE});

  // ****************************************
  // Exception frame sender
  // ****************************************
  // exception frame on refusal
  always_comb begin
    txState_d = txState_q;
    case (txState_q)
      emx_pkg::TX_IDLE: begin
        if (take && kind == emx_pkg::RSP_EXCEPT) begin
          txState_d = emx_pkg::TX_ADDR;
        end
      end
      emx_pkg::TX_ADDR: begin
        if (acc) begin
          txState_d = emx_pkg::TX_FUNC;
        end
      end
      emx_pkg::TX_FUNC: begin
        if (acc) begin
          txState_d = emx_pkg::TX_CODE;
        end
      end
      emx_pkg::TX_CODE: begin
        if (acc) begin
          txState_d = emx_pkg::TX_WAIT;
        end
      end
      emx_pkg::TX_WAIT: begin
        txState_d = emx_pkg::TX_CRCL;
      end
      emx_pkg::TX_CRCL: begin
        if (acc) begin
          txState_d = emx_pkg::TX_CRCH;
        end
      end
      emx_pkg::TX_CRCH: begin
        if (acc) begin
          txState_d = emx_pkg::TX_IDLE;
        end
      end
      default: begin
        txState_d = emx_pkg::TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      txState_q <= emx_pkg::TX_IDLE;
    end else begin
      txState_q <= txState_d;
    end
  end

  // Byte presented for each state entered
  always_ff @(posedge core_clk) begin
    if (srst) begin
      txByte <= 8'h00;
    end else if (txState_d != txState_q) begin
      case (txState_d)
        emx_pkg::TX_ADDR: begin
          txByte <= nodeAddr;
        end
        emx_pkg::TX_FUNC: begin
          txByte <= rspFunc;
        end
        emx_pkg::TX_CODE: begin
          txByte <= rspCode;
        end
        emx_pkg::TX_CRCL: begin
          txByte <= crcBus.crc[7:0];
        end
        emx_pkg::TX_CRCH: begin
          txByte <= crcBus.crc[15:8];
        end
        default: begin
          txByte <= 8'h00;
        end
      endcase
    end
  end

  // Frame strobe and flags
  always_ff @(posedge core_clk) begin
    if (srst) begin
      txValid <= 1'b0;
    end else begin
      txValid <= txState_d inside {emx_pkg::TX_ADDR, emx_pkg::TX_FUNC, emx_pkg::TX_CODE,
                                   emx_pkg::TX_CRCL, emx_pkg::TX_CRCH};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      txLast <= 1'b0;
    end else begin
      txLast <= txState_d == emx_pkg::TX_CRCH;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      senderBusy <= 1'b0;
    end else begin
      senderBusy <= txState_d != emx_pkg::TX_IDLE;
    end
  end

  // ****************************************
  // Status word
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      statusWord <= emx_pkg::ST_RESET;
    end else begin
      statusWord <= emx_pkg::ST_RESET;
      statusWord[emx_pkg::ST_SCALE_BIT] <= scaleSet;
      statusWord[emx_pkg::ST_DIR_BIT]   <= codeSeqSet;
      statusWord[emx_pkg::ST_ALARM_BIT] <= |alarmVec;
    end
  end

endmodule

// ---- verilog/emx_pkg.sv ----
// Constants and types for the exception and status logic
package emx_pkg;

  // ****************************************
  // Function codes
  // ****************************************
  localparam logic [7:0] FC_READ_HOLD  = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_ONE  = 8'h06;
  localparam logic [7:0] FC_WRITE_MANY = 8'h10;
  localparam logic [7:0] FC_FILE_READ  = 8'h14;
  localparam logic [7:0] FC_FILE_WRITE = 8'h15;
  localparam logic [7:0] FC_EXC_FLAG   = 8'h80;
  localparam logic [7:0] FILE_REF_TYPE = 8'h06;

  // ****************************************
  // Exception codes
  // ****************************************
  localparam logic [7:0] EXC_FUNC      = 8'h01;
  localparam logic [7:0] EXC_ADDR      = 8'h02;
  localparam logic [7:0] EXC_VALUE     = 8'h03;
  localparam logic [7:0] EXC_FAILURE   = 8'h04;
  localparam logic [7:0] EXC_ACK       = 8'h05;
  localparam logic [7:0] EXC_BUSY      = 8'h06;
  localparam logic [7:0] EXC_PARITY    = 8'h08;
  localparam logic [7:0] EXC_GW_PATH   = 8'h0A;
  localparam logic [7:0] EXC_GW_TARGET = 8'h0B;

  // ****************************************
  // Quantity limits and register counts
  // ****************************************
  localparam logic [15:0] QTY_READ_MAX  = 16'h007D;
  localparam logic [15:0] QTY_WRITE_MAX = 16'h007B;
  localparam int          HOLD_REG_CNT  = 11;
  localparam int          INPUT_REG_CNT = 7;

  // ****************************************
  // Status word layout, reset values and checksum polynomial
  // ****************************************
  localparam int          ST_SCALE_BIT = 0;
  localparam int          ST_DIR_BIT   = 1;
  localparam int          ST_ALARM_BIT = 8;
  localparam logic [15:0] ST_RESET     = 16'h0000;
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] CRC_POLY     = 16'hA001;

  // ****************************************
  // Reply kinds and sender states
  // ****************************************
  typedef enum logic [1:0] {
    RSP_NONE   = 2'b00,
    RSP_NORMAL = 2'b01,
    RSP_EXCEPT = 2'b10
  } emx_rsp_t;

  typedef enum logic [6:0] {
    TX_IDLE = 7'b000_0001,
    TX_ADDR = 7'b000_0010,
    TX_FUNC = 7'b000_0100,
    TX_CODE = 7'b000_1000,
    TX_WAIT = 7'b001_0000,
    TX_CRCL = 7'b010_0000,
    TX_CRCH = 7'b100_0000
  } emx_tx_t;

endpackage
